// File: rtl/mtm_top.sv
// seven channel temperature monitor: smbus slave, sequencer, alarms
`include "mtm_cfg.svh"
module mtm_top #(
	parameter logic [6:0]    SLAVE_ADDR = 7'h2a,
	parameter logic [7:0]    DEVICE_ID  = 8'h5c, // arbitrary value
	parameter int            CW         = 21,
	parameter logic [CW-1:0] FAULT_CYC  = CW'(`MTM_FAULT_MS * `MTM_CLK_KHZ),
	parameter logic [CW-1:0] TOUT_CYC   = CW'(`MTM_TOUT_MS * `MTM_CLK_KHZ)
) (
	input  logic             ref_clk,
	input  logic             rst_b,
	input  logic             clk_en,
	input  logic             hw_sleep_n,
	input  logic             serial_clock_pin,
	input  logic             serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	output logic             alert_out_n,
	output logic             alert_oe,
	output logic             overtemp_out_n,
	output logic             overtemp_oe,
	output logic             adc_start,
	output logic [2:0]       adc_chan,
	input  mtm_pkg::mtm_adc_t adc_result,
	input  logic             adc_valid,
	output logic             res_cancel_en,
	output logic             beta_comp_en
);
	localparam logic [3:0][2:0] OV_CH = `MTM_OV_CHANS;

	logic [1:0]         scl_sy, sda_sy, slp_sy;
	logic               scl_d, sda_d;
	logic               scl, sda, awake;
	logic               scl_rise, scl_fall, start_c, stop_c;
	mtm_pkg::mtm_smb_t  smb_st;
	mtm_pkg::mtm_seq_t  seq_st;
	logic [3:0]         bit_cnt_r;
	logic [1:0]         byte_idx_r;
	logic [7:0]         sh_r, ptr_r, cfg1_r, cfg2_r, cfg3_r, ext_r;
	logic [7:0]         tx_byte, conv_hi, st2_v;
	logic               rd_r, ara_r, sda_oe_r, soft_rst_r;
	logic [6:0][7:0]    temp_r, alim_r;
	logic [3:0][7:0]    olim_r;
	logic [6:0]         st1_r, st1_set;
	logic [5:0]         st3_r;
	logic [3:0]         ov_r;
	logic               alert_r, alert_n_r, ovt_oe_r, ovt_n_r;
	logic               lock_r, adc_start_r;
	logic [CW-1:0]      lock_cnt_r, to_cnt_r, wd_cnt_r;
	logic [2:0]         chan_r;
	logic               rx_done, wr_stb, cmd_stb, tx_load, rd_stb, ara_ok;
	logic               bus_to, standby, conv_end, ov_any;
	mtm_pkg::mtm_adc_t  cres;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
		input logic [2:0] i);
		return a == b + 8'(i);
	endfunction : hit

	function automatic logic [7:0] enc_hi(input mtm_pkg::mtm_adc_t r);
		if (r.fault)
			return `MTM_T_FAULT;
		if (r.temp < 0)
			return `MTM_T_ZERO;
		if (r.temp >= `MTM_T_SAT)
			return `MTM_T_MAX;
		return r.temp[10:3];
	endfunction : enc_hi

	function automatic logic [2:0] next_chan(input logic [2:0] c);
		case (c)
			`MTM_CH_PRE_LOC: return `MTM_CH_LOCAL;
			`MTM_CH_LOCAL:   return `MTM_CH_POST_LOC;
			`MTM_CH_LAST:    return `MTM_CH_FIRST;
			default:         return c + 3'h1;
		endcase
	endfunction : next_chan

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < 7; i++)
		begin
			if (hit(a, `MTM_A_TEMP, 3'(i)))
				d = temp_r[i];
			if (hit(a, `MTM_A_ALIM, 3'(i)))
				d = alim_r[i];
		end
		for (int k = 0; k < 4; k++)
			if (hit(a, `MTM_A_OLIM, OV_CH[k]))
				d = olim_r[k];
		case (a)
			`MTM_A_EXT:  d = ext_r;
			`MTM_A_ID:   d = DEVICE_ID;
			`MTM_A_CFG1: d = cfg1_r;
			`MTM_A_CFG2: d = cfg2_r;
			`MTM_A_CFG3: d = cfg3_r;
			`MTM_A_ST1:  d = {1'b0, st1_r};
			`MTM_A_ST2:  d = st2_v;
			`MTM_A_ST3:  d = {2'b00, st3_r};
			default:     ;
		endcase
		return d;
	endfunction : reg_read

	// pins pass two flops; edges are found on the second stage only
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			scl_sy <= 2'b11;
			sda_sy <= 2'b11;
			slp_sy <= 2'b11;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end
		else if (clk_en)
		begin
			scl_sy <= {scl_sy[0], serial_clock_pin};
			sda_sy <= {sda_sy[0], serial_data_in};
			slp_sy <= {slp_sy[0], hw_sleep_n};
			scl_d  <= scl_sy[1];
			sda_d  <= sda_sy[1];
		end

	assign scl      = scl_sy[1];
	assign sda      = sda_sy[1];
	assign awake    = slp_sy[1];
	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_c  = scl & scl_d & sda_d & ~sda;
	assign stop_c   = scl & scl_d & ~sda_d & sda;

	assign rx_done = smb_st == mtm_pkg::SMB_RX && scl_fall &&
		bit_cnt_r == `MTM_BITS;
	assign cmd_stb = rx_done && byte_idx_r == `MTM_IDX_CMD;
	assign wr_stb  = rx_done && byte_idx_r == `MTM_IDX_DATA;
	assign tx_load = scl_fall && ((smb_st == mtm_pkg::SMB_ACK && rd_r) ||
		smb_st == mtm_pkg::SMB_MACK);
	assign rd_stb  = tx_load && !ara_r;
	assign ara_ok  = smb_st == mtm_pkg::SMB_TX && scl_fall && ara_r &&
		bit_cnt_r == `MTM_BITS;
	// a process so that it wakes on every register the lookup reads
	always_comb
		tx_byte = ara_r ? {SLAVE_ADDR, 1'b0} : reg_read(ptr_r);
	assign bus_to  = !cfg1_r[`MTM_B_TODIS] && to_cnt_r == TOUT_CYC;

	// stuck-low clock watchdog frees the data line
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			to_cnt_r <= '0;
		else if (clk_en)
			to_cnt_r <= (scl || smb_st == mtm_pkg::SMB_IDLE || bus_to) ?
				'0 : to_cnt_r + CW'(1);

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			smb_st     <= mtm_pkg::SMB_IDLE;
			bit_cnt_r  <= '0;
			byte_idx_r <= '0;
			sh_r       <= '0;
			rd_r       <= 1'b0;
			ara_r      <= 1'b0;
			sda_oe_r   <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!awake || bus_to || stop_c)
			begin
				smb_st   <= mtm_pkg::SMB_IDLE;
				sda_oe_r <= 1'b0;
			end
			else if (start_c)
			begin
				smb_st     <= mtm_pkg::SMB_RX;
				bit_cnt_r  <= '0;
				byte_idx_r <= '0;
				sda_oe_r   <= 1'b0;
			end
			else
			begin
				unique case (smb_st)
					mtm_pkg::SMB_IDLE: ;
					mtm_pkg::SMB_RX:
					begin
						if (scl_rise)
						begin
							sh_r      <= {sh_r[6:0], sda};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
						else if (rx_done)
						begin
							smb_st   <= mtm_pkg::SMB_ACK;
							sda_oe_r <= 1'b1;
							if (byte_idx_r == 2'h0)
							begin
								rd_r  <= sh_r[0];
								ara_r <= sh_r[7:1] == `MTM_ARA;
								if (sh_r[7:1] == `MTM_ARA)
								begin
									if (!sh_r[0] || !alert_r)
									begin
										smb_st   <= mtm_pkg::SMB_IDLE;
										sda_oe_r <= 1'b0;
									end
								end
								else if (sh_r[7:1] != SLAVE_ADDR)
								begin
									smb_st   <= mtm_pkg::SMB_IDLE;
									sda_oe_r <= 1'b0;
								end
							end
						end
					end
					mtm_pkg::SMB_ACK:
						if (scl_fall)
						begin
							bit_cnt_r <= '0;
							if (rd_r)
							begin
								smb_st   <= mtm_pkg::SMB_TX;
								sh_r     <= tx_byte;
								sda_oe_r <= ~tx_byte[7];
							end
							else
							begin
								smb_st   <= mtm_pkg::SMB_RX;
								sda_oe_r <= 1'b0;
								if (byte_idx_r != `MTM_IDX_MAX)
									byte_idx_r <= byte_idx_r + 2'h1;
							end
						end
					mtm_pkg::SMB_TX:
						if (scl_rise)
						begin
							bit_cnt_r <= bit_cnt_r + 4'h1;
							if (ara_r && sh_r[7] && !sda)
							begin
								smb_st   <= mtm_pkg::SMB_IDLE;
								sda_oe_r <= 1'b0;
							end
						end
						else if (scl_fall)
						begin
							if (bit_cnt_r == `MTM_BITS)
							begin
								smb_st   <= mtm_pkg::SMB_MACK;
								sda_oe_r <= 1'b0;
							end
							else
							begin
								sh_r     <= {sh_r[6:0], 1'b0};
								sda_oe_r <= ~sh_r[6];
							end
						end
					mtm_pkg::SMB_MACK:
						if (scl_rise && sda)
							smb_st <= mtm_pkg::SMB_IDLE;
						else if (scl_fall)
						begin
							smb_st    <= mtm_pkg::SMB_TX;
							bit_cnt_r <= '0;
							sh_r      <= tx_byte;
							sda_oe_r  <= ~tx_byte[7];
						end
					default:
						smb_st <= mtm_pkg::SMB_IDLE;
				endcase
			end
		end

	ack_slot_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && awake && rx_done && byte_idx_r != 2'h0 |=> sda_oe_r)
		else $error("written byte not acknowledged");

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			ptr_r <= `MTM_PTR_RST;
		else if (clk_en)
		begin
			if (soft_rst_r)
				ptr_r <= `MTM_PTR_RST;
			else if (cmd_stb)
				ptr_r <= sh_r;
		end

	ptr_reset_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && soft_rst_r |=> ptr_r == `MTM_PTR_RST)
		else $error("pointer not cleared by soft reset");

	// configuration and thresholds
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			cfg1_r     <= `MTM_CFG1_RST;
			cfg2_r     <= `MTM_CFG23_RST;
			cfg3_r     <= `MTM_CFG23_RST;
			alim_r     <= `MTM_ALIM_RST;
			olim_r     <= `MTM_OLIM_RST;
			soft_rst_r <= 1'b0;
		end
		else if (clk_en)
		begin
			soft_rst_r <= wr_stb && ptr_r == `MTM_A_CFG1 &&
				sh_r[`MTM_B_SRST];
			if (soft_rst_r)
			begin
				cfg1_r <= `MTM_CFG1_RST;
				cfg2_r <= `MTM_CFG23_RST;
				cfg3_r <= `MTM_CFG23_RST;
				alim_r <= `MTM_ALIM_RST;
				olim_r <= `MTM_OLIM_RST;
			end
			else if (wr_stb)
			begin
				// reserved bits and the self-clearing bit never store
				if (ptr_r == `MTM_A_CFG1)
					cfg1_r <= sh_r & `MTM_CFG1_WMASK;
				if (ptr_r == `MTM_A_CFG2)
					cfg2_r <= sh_r & `MTM_CFG2_WMASK;
				if (ptr_r == `MTM_A_CFG3)
					cfg3_r <= sh_r & `MTM_CFG3_WMASK;
				for (int i = 0; i < 7; i++)
					if (hit(ptr_r, `MTM_A_ALIM, 3'(i)))
						alim_r[i] <= sh_r;
				for (int k = 0; k < 4; k++)
					if (hit(ptr_r, `MTM_A_OLIM, OV_CH[k]))
						olim_r[k] <= sh_r;
			end
		end

	self_clear_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && soft_rst_r |=> !soft_rst_r && !cfg1_r[`MTM_B_SRST] &&
			cfg1_r == `MTM_CFG1_RST)
		else $error("soft reset did not restore config 1");

	// conversion sequencer; alarm state never stalls it
	assign standby  = cfg1_r[`MTM_B_STOP] || !awake;
	assign conv_end = seq_st == mtm_pkg::SEQ_CONV && !standby &&
		(adc_valid || wd_cnt_r == FAULT_CYC);
	assign cres     = adc_valid ? adc_result :
		mtm_pkg::mtm_adc_t'{fault: 1'b1, temp: '0};
	assign conv_hi  = enc_hi(cres);

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			seq_st      <= mtm_pkg::SEQ_IDLE;
			chan_r      <= `MTM_CH_FIRST;
			wd_cnt_r    <= '0;
			adc_start_r <= 1'b0;
		end
		else if (clk_en)
		begin
			adc_start_r <= 1'b0;
			if (soft_rst_r)
			begin
				seq_st <= mtm_pkg::SEQ_IDLE;
				chan_r <= `MTM_CH_FIRST;
			end
			else
			begin
				unique case (seq_st)
					mtm_pkg::SEQ_IDLE:
						if (!standby)
						begin
							seq_st      <= mtm_pkg::SEQ_CONV;
							adc_start_r <= 1'b1;
							wd_cnt_r    <= '0;
						end
					mtm_pkg::SEQ_CONV:
						if (standby || conv_end)
						begin
							seq_st <= mtm_pkg::SEQ_IDLE;
							if (conv_end)
								chan_r <= next_chan(chan_r);
						end
						else
							wd_cnt_r <= wd_cnt_r + CW'(1);
				endcase
			end
		end

	standby_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && cfg1_r[`MTM_B_STOP] |=> !adc_start_r)
		else $error("conversion started in standby");

	// results, fault flags and the channel 1 read lock
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			temp_r <= '0;
			ext_r  <= '0;
			st3_r  <= '0;
		end
		else if (clk_en)
		begin
			if (soft_rst_r)
			begin
				temp_r <= '0;
				ext_r  <= '0;
				st3_r  <= '0;
			end
			else if (conv_end)
			begin
				if (!(chan_r == `MTM_CH_FIRST && lock_r))
					temp_r[chan_r] <= conv_hi;
				if (chan_r == `MTM_CH_FIRST)
					ext_r <= (cres.fault || cres.temp < 0 ||
						cres.temp >= `MTM_T_SAT) ? '0 :
						{cres.temp[2:0], `MTM_FRAC_PAD};
				if (chan_r != `MTM_CH_LOCAL)
					st3_r[chan_r] <= cres.fault;
			end
		end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			lock_r     <= 1'b0;
			lock_cnt_r <= '0;
		end
		else if (clk_en)
		begin
			lock_cnt_r <= lock_r ? lock_cnt_r + CW'(1) : '0;
			if (soft_rst_r || lock_cnt_r == TOUT_CYC)
				lock_r <= 1'b0;
			else if (rd_stb && ptr_r == `MTM_A_EXT)
				lock_r <= 1'b1;
			else if (rd_stb && ptr_r == `MTM_A_TEMP)
				lock_r <= 1'b0;
		end

	fault_store_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && conv_end && cres.fault && !soft_rst_r &&
			chan_r != `MTM_CH_FIRST |=> temp_r[$past(chan_r)] == `MTM_T_FAULT)
		else $error("fault did not store ff");

	ext_lock_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			lock_r && !soft_rst_r |=> $stable(temp_r[0]))
		else $error("locked channel 1 byte changed");

	// alert status and interrupt latch; masks gate only the latch
	always_comb
	begin
		st1_set = '0;
		if (conv_end && !cres.fault)
			st1_set[chan_r] = conv_hi > alim_r[chan_r];
	end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			st1_r     <= '0;
			alert_r   <= 1'b0;
			alert_n_r <= 1'b1;
		end
		else if (clk_en)
		begin
			// a new event beats a clear in the same cycle
			st1_r <= (soft_rst_r || (rd_stb && ptr_r == `MTM_A_ST1)) ?
				st1_set : st1_r | st1_set;
			alert_r <= |(st1_set & ~cfg2_r[6:0]) || (alert_r && !soft_rst_r &&
				!(rd_stb && ptr_r == `MTM_A_ST1) && !ara_ok);
			alert_n_r <= !(|(st1_set & ~cfg2_r[6:0]) || (alert_r &&
				!soft_rst_r && !(rd_stb && ptr_r == `MTM_A_ST1) && !ara_ok));
		end

	alert_set_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && |(st1_set & ~cfg2_r[6:0]) |=> alert_r && !alert_n_r)
		else $error("interrupt not raised on exceeded limit");

	alert_clear_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && ara_ok && st1_set == '0 |=> !alert_r)
		else $error("alert response did not release interrupt");

	// overtemp with hysteresis; open diode reads never compare
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			ov_r <= '0;
		else if (clk_en)
		begin
			if (soft_rst_r)
				ov_r <= '0;
			else if (conv_end && !cres.fault)
				for (int k = 0; k < 4; k++)
					if (chan_r == OV_CH[k])
					begin
						if (conv_hi > olim_r[k])
							ov_r[k] <= 1'b1;
						else if ({1'b0, conv_hi} + `MTM_HYST < {1'b0, olim_r[k]})
							ov_r[k] <= 1'b0;
					end
		end

	always_comb
	begin
		st2_v  = '0;
		ov_any = 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			st2_v[OV_CH[k]] = ov_r[k];
			ov_any = ov_any | (ov_r[k] & ~cfg3_r[OV_CH[k]]);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			ovt_oe_r <= 1'b0;
			ovt_n_r  <= 1'b1;
		end
		else if (clk_en)
		begin
			ovt_oe_r <= ov_any;
			ovt_n_r  <= !ov_any;
		end

	ovt_hyst_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && !$past(soft_rst_r) && $fell(ov_r[2]) |->
			$past(conv_end) && $past(chan_r) == OV_CH[2] &&
			{1'b0, $past(conv_hi)} + `MTM_HYST < {1'b0, $past(olim_r[2])})
		else $error("overtemp released inside its hysteresis band");

	ovt_mask_a:
		assert property (@(posedge ref_clk) disable iff (!rst_b)
			clk_en && cfg3_r == `MTM_CFG3_WMASK |=> !ovt_oe_r)
		else $error("masked overtemp still drives output");

	// open drain pins only ever pull low
	assign serial_data_out = 1'b0;
	assign serial_data_oe  = sda_oe_r;
	assign alert_out_n     = alert_n_r;
	assign alert_oe        = alert_r;
	assign overtemp_out_n  = ovt_n_r;
	assign overtemp_oe     = ovt_oe_r;
	assign adc_start       = adc_start_r;
	assign adc_chan        = chan_r;
	assign res_cancel_en   = cfg1_r[`MTM_B_RC];
	assign beta_comp_en    = cfg1_r[`MTM_B_BETA];
endmodule : mtm_top

// File: shared/mtm_cfg.svh
// register map, reset values and timing for the temperature monitor
`ifndef MTM_CFG_SVH
`define MTM_CFG_SVH
`define MTM_A_TEMP      8'h01
`define MTM_A_EXT       8'h09
`define MTM_A_ID        8'h0a
`define MTM_A_ALIM      8'h11
`define MTM_A_OLIM      8'h21
`define MTM_A_CFG1      8'h41
`define MTM_A_CFG2      8'h42
`define MTM_A_CFG3      8'h43
`define MTM_A_ST1       8'h44
`define MTM_A_ST2       8'h45
`define MTM_A_ST3       8'h46
`define MTM_PTR_RST     8'h00
`define MTM_CFG1_RST    8'h0c
`define MTM_CFG23_RST   8'h00
`define MTM_CFG1_WMASK  8'hac
`define MTM_CFG2_WMASK  8'h7f
`define MTM_CFG3_WMASK  8'h39
`define MTM_B_STOP      7
`define MTM_B_SRST      6
`define MTM_B_TODIS     5
`define MTM_B_RC        3
`define MTM_B_BETA      2
`define MTM_ALIM_RST    {8'h5a, 8'h64, 8'h64, 8'h64, 8'h64, 8'h7f, 8'h6e}
`define MTM_OLIM_RST    {8'h5a, 8'h5a, 8'h7f, 8'h6e}
`define MTM_OV_CHANS    {3'h5, 3'h4, 3'h3, 3'h0}
`define MTM_T_MAX       8'h7f
`define MTM_T_ZERO      8'h00
`define MTM_T_FAULT     8'hff
`define MTM_T_SAT       12'sh400
`define MTM_FRAC_PAD    5'h00
`define MTM_HYST        9'h004
`define MTM_ARA         7'h0c
`define MTM_BITS        4'h8
`define MTM_IDX_CMD     2'h1
`define MTM_IDX_DATA    2'h2
`define MTM_IDX_MAX     2'h3
`define MTM_CH_FIRST    3'h0
`define MTM_CH_PRE_LOC  3'h2
`define MTM_CH_LOCAL    3'h6
`define MTM_CH_POST_LOC 3'h3
`define MTM_CH_LAST     3'h5
`define MTM_FAULT_MS    4
`define MTM_TOUT_MS     37
`define MTM_CLK_KHZ     40000
`endif

// File: shared/mtm_pkg.sv
// types shared by the temperature monitor
package mtm_pkg;
	typedef enum logic [2:0] {
		SMB_IDLE = 3'b000,
		SMB_RX   = 3'b001,
		SMB_ACK  = 3'b010,
		SMB_TX   = 3'b011,
		SMB_MACK = 3'b100
	} mtm_smb_t;
	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_CONV = 1'b1
	} mtm_seq_t;
	typedef struct packed {
		logic               fault;
		logic signed [11:0] temp;
	} mtm_adc_t;
endpackage : mtm_pkg

// File: tb/mtm_host.sv
// smbus host model driving a wired-and data line and the clock pin
module mtm_host (
	input  wire logic ref_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// half of a 200 ns link period, moved on the falling edge
	task automatic half();
		repeat (4) @(negedge ref_clk);
	endtask : half
	task automatic bit_io(input logic b, output logic s);
		sda_oe = !b;
		half();
		scl = 1'b1;
		half();
		s = sda;
		scl = 1'b0;
	endtask : bit_io
	// start and repeated start alike; clock stands still between frames
	task automatic start();
		sda_oe = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_oe = 1'b1;
		half();
		scl = 1'b0;
	endtask : start
	task automatic stop();
		sda_oe = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_oe = 1'b0;
		half();
	endtask : stop
	// msb first; ninth bit released for a slave ack or as master no-ack
	task automatic xfer(input logic [7:0] d, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, s);
		ack = !s;
	endtask : xfer
	task automatic wr(input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] d, input logic with_d, output logic ok);
		logic [7:0] x;
		logic       k1, k2, k3;
		start();
		xfer({a, 1'b0}, x, k1);
		xfer(c, x, k2);
		k3 = 1'b1;
		if (with_d)
			xfer(d, x, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] c,
		input logic with_c, output logic [7:0] q, output logic ok);
		logic [7:0] x;
		logic       k1, k2, k3, k4;
		k1 = 1'b1;
		k2 = 1'b1;
		if (with_c)
		begin
			start();
			xfer({a, 1'b0}, x, k1);
			xfer(c, x, k2);
		end
		start();
		xfer({a, 1'b1}, x, k3);
		xfer(8'hff, q, k4);
		stop();
		ok = k1 & k2 & k3;
	endtask : rd
	// alert response read while another responder drives its own address
	task automatic ara(input logic [7:0] d, output logic [7:0] q,
		output logic ok);
		logic [7:0] x;
		logic       k;
		start();
		xfer({7'h0c, 1'b1}, x, ok);
		xfer(d, q, k);
		stop();
	endtask : ara
	// read that parks the clock low after the address ack, before the data byte, then clocks the byte out
	task automatic hang(input logic [6:0] a, input int n,
		output logic held);
		logic [7:0] x;
		logic       k;
		start();
		xfer({a, 1'b1}, x, k);
		repeat (n) @(negedge ref_clk);
		held = !sda;
		xfer(8'hff, x, k);
		stop();
	endtask : hang
endmodule : mtm_host

// File: tb/testbench.sv
// self-checking bench for the temperature monitor
`define CHK(n, e, g) chk(n, e, g)
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] SA = 7'h2a;
	logic              ref_clk, rst_b, hw_sleep_n, scl, h_oe, sd_out, sd_oe;
	logic              al_n, al_oe, ov_n, ov_oe, adc_start, adc_valid;
	logic              rc_en, bc_en, ok;
	logic [2:0]        adc_chan, adc_ch;
	logic [3:0]        adc_cnt;
	logic [6:0]        flt;
	logic [7:0]        q;
	logic signed [11:0] tmp [7];
	mtm_pkg::mtm_adc_t adc_result;
	int                error_cnt, n_compared, cyc, n_st;
	wire               sda = !h_oe & (!sd_oe | sd_out);

	mtm_top #(.SLAVE_ADDR(SA), .FAULT_CYC(21'd50), .TOUT_CYC(21'd2000)) DUT (
		.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1),
		.hw_sleep_n(hw_sleep_n), .serial_clock_pin(scl),
		.serial_data_in(sda), .serial_data_out(sd_out),
		.serial_data_oe(sd_oe), .alert_out_n(al_n), .alert_oe(al_oe),
		.overtemp_out_n(ov_n), .overtemp_oe(ov_oe), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_result(adc_result),
		.adc_valid(adc_valid), .res_cancel_en(rc_en), .beta_comp_en(bc_en));
	mtm_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_oe(h_oe));

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = !ref_clk;
	end
	// converter answers 8 cycles after start; a faulted channel never answers
	always @(negedge ref_clk)
	begin
		adc_valid <= 1'b0;
		if (adc_cnt != 4'h0)
			adc_cnt <= adc_cnt - 4'h1;
		if (adc_cnt == 4'h1 && !flt[adc_ch])
		begin
			adc_valid <= 1'b1;
			adc_result <= '{1'b0, tmp[adc_ch]};
		end
		if (adc_start)
		begin
			adc_cnt <= 4'h8;
			adc_ch <= adc_chan;
		end
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (adc_start)
			n_st++;
		if (cyc == 40000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic rr(input logic [7:0] a, input logic [7:0] e);
		host.rd(SA, a, 1'b1, q, ok);
		`CHK("read ack", 8'h01, {7'h0, ok});
		`CHK($sformatf("reg %h", a), e, q);
	endtask : rr
	task automatic ww(input logic [7:0] a, input logic [7:0] d);
		host.wr(SA, a, d, 1'b1, ok);
		`CHK("write ack", 8'h01, {7'h0, ok});
	endtask : ww
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wt
	// pins packed as {alert_n, overtemp_n}
	task automatic pins(input logic [1:0] e);
		`CHK("pins", {6'h0, e}, {6'h0, al_n, ov_n});
	endtask : pins
	function automatic logic [7:0] hb(input int t8, input logic f);
		if (f)
			return 8'hff;
		if (t8 < 0)
			return 8'h00;
		if (t8 > 1023)
			return 8'h7f;
		return t8[10:3];
	endfunction : hb
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	initial
	begin
		rst_b = 1'b0;
		hw_sleep_n = 1'b1;
		adc_valid = 1'b0;
		adc_result = '0;
		adc_cnt = 4'h0;
		adc_ch = 3'h0;
		flt = 7'h08;
		tmp = '{12'sd244, -12'sd320, 12'sd0, 12'sd0, 12'sd160, 12'sd160,
			12'sd200};
		wt(5);
		rst_b = 1'b1;
		host.rd(SA, 8'h00, 1'b0, q, ok);
		`CHK("pointer", 8'h00, q);
		host.rd(7'h0c, 8'h00, 1'b0, q, ok);
		`CHK("idle ara", 8'h00, {7'h0, ok});
		rr(8'h41, 8'h0c);
		rr(8'h42, 8'h00);
		rr(8'h43, 8'h00);
		rr(8'h30, 8'h00);
		`CHK("corr", 8'h03, {6'h0, rc_en, bc_en});
		$display("test reset done");
		tmp[2] = 12'sd1600;
		tmp[4] = 12'sd880;
		wt(400);
		for (int i = 0; i < 7; i++)
			rr(8'h01 + 8'(i), hb(tmp[i], flt[i]));
		rr(8'h09, {tmp[0][2:0], 5'h00});
		tmp[0] = 12'sd320;
		wt(300);
		rr(8'h01, 8'h1e);
		wt(300);
		rr(8'h01, hb(tmp[0], 1'b0));
		rr(8'h09, 8'h00);
		tmp[0] = 12'sd400;
		wt(2100);
		rr(8'h01, hb(tmp[0], 1'b0));
		rr(8'h46, 8'h08);
		rr(8'h45, 8'h10);
		pins(2'b00);
		$display("test results done");
		ww(8'h41, 8'h8c);
		wt(50);
		n_st = 0;
		rr(8'h44, 8'h14);
		pins(2'b10);
		`CHK("starts", 8'h00, 8'(n_st));
		ww(8'h41, 8'h0c);
		wt(400);
		pins(2'b00);
		n_st = 0;
		wt(100);
		`CHK("running", 8'h01, {7'h0, n_st > 0});
		ww(8'h41, 8'h8c);
		wt(50);
		host.ara(8'h20, q, ok);
		`CHK("ara lost", 8'h20, q);
		pins(2'b00);
		host.rd(7'h0c, 8'h00, 1'b0, q, ok);
		`CHK("ara ack", 8'h01, {7'h0, ok});
		`CHK("ara addr", {SA, 1'b0}, q);
		pins(2'b10);
		ww(8'h41, 8'h0c);
		$display("test alert done");
		tmp[4] = 12'sd704;
		wt(400);
		pins(2'b00);
		tmp[4] = 12'sd680;
		wt(400);
		pins(2'b01);
		$display("test hysteresis done");
		ww(8'h42, 8'h14);
		ww(8'h43, 8'hff);
		rr(8'h43, 8'h39);
		rr(8'h44, 8'h14);
		tmp[4] = 12'sd880;
		wt(400);
		pins(2'b11);
		rr(8'h45, 8'h10);
		rr(8'h44, 8'h14);
		host.wr(SA, 8'h42, 8'h00, 1'b0, ok);
		`CHK("send ack", 8'h01, {7'h0, ok});
		host.rd(SA, 8'h00, 1'b0, q, ok);
		`CHK("receive", 8'h14, q);
		$display("test masks done");
		ww(8'h41, 8'h2c);
		host.hang(SA, 2100, ok);
		`CHK("timeout off", 8'h01, {7'h0, ok});
		ww(8'h41, 8'h0c);
		host.hang(SA, 2100, ok);
		`CHK("timeout on", 8'h00, {7'h0, ok});
		rr(8'h17, 8'h5a);
		rr(8'h24, 8'h7f);
		ww(8'h26, 8'h33);
		rr(8'h26, 8'h33);
		ww(8'h41, 8'h40);
		rr(8'h41, 8'h0c);
		rr(8'h42, 8'h00);
		rr(8'h26, 8'h5a);
		ww(8'h41, 8'h8c);
		hw_sleep_n = 1'b0;
		wt(4);
		host.rd(SA, 8'h41, 1'b1, q, ok);
		`CHK("sleep ack", 8'h00, {7'h0, ok});
		hw_sleep_n = 1'b1;
		wt(4);
		rr(8'h41, 8'h8c);
		$display("test standby done");
		stop_test();
	end
endmodule : testbench
